// ==== hdl/clk_stop_power_control.sv ====
// Clock stop gating and power-up strap capture for the clock synthesizer outputs.
// Assumes rst is the power-on reset and supply_ok rises once the core supply is good.
`timescale 1ns/10ps
`default_nettype none
module clk_stop_power_control
    import clk_stop_pkg::*;
#(
    parameter int unsigned POWERUP_CYCLES = POWERUP_CYCLES_DEF
)(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Power management pins from the chipset
    input  wire logic                 cpu_stop_n,
    input  wire logic                 pci_stop_n,
    // Supply monitor
    input  wire logic                 supply_ok,
    // Dual-function pins
    input  wire logic [DUAL_PINS-1:0] dual_in,
    output logic      [DUAL_PINS-1:0] dual_out,
    output logic      [DUAL_PINS-1:0] dual_oe,
    // Captured selections for the synthesizer
    output logic      [DUAL_PINS-1:0] strap_sel,
    output logic                      strap_valid,
    // Clock outputs
    output logic      [CPU_CLOCKS-1:0]      cpu_clocks,
    output logic      [PCI_STOP_CLOCKS-1:0] stoppable_pci_clocks,
    output logic                            free_running_pci_clock
);

    // All control state except the gate enables lives in one record. The synchronisers sit at its head,
    // so nothing further down ever reads a raw pin.
    typedef struct packed {
        logic [DIV_W-1:0]     div;
        logic [1:0]           cpu_sync;
        logic [1:0]           pci_sync;
        logic [1:0]           supply_sync;
        logic [DUAL_PINS-1:0] strap_s1;
        logic [DUAL_PINS-1:0] strap_s2;
        pwr_state_e           pwr;
        logic [TIMER_W-1:0]   timer;
        logic [DUAL_PINS-1:0] sel;
        logic                 sel_valid;
        dual_drive_s          dual;
        logic                 pci_free;
    } ctrl_s;

    ctrl_s     ctrl_r;
    ctrl_s     ctrl_nxt;
    clk_outs_s clk_outs;

    localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(POWERUP_CYCLES - 1);

    // Next levels of the two ungated waves. Each gate registers its own copy of
    // the wave, so a gated output and the free-running one switch on the same
    // edge and stay in phase with no extra delay on either.
    logic cpu_wave_nxt;
    logic pci_wave_nxt;

    // Pick one divided clock out of the divider state.
    function automatic logic wave_of(input logic [DIV_W-1:0] div, input int unsigned bit_sel);
        logic w;
        w = div[bit_sel];
        return w;
    endfunction

    always_comb begin
        ctrl_nxt = ctrl_r;

        // The divider never stops, so every output that is not gated keeps running.
        ctrl_nxt.div      = ctrl_r.div + DIV_W'(1);
        ctrl_nxt.pci_free = wave_of(ctrl_nxt.div, PCI_DIV_BIT);

        // Two flip-flops on every pin before anything looks at it. The chipset already
        // moves the stop pins on free-running PCI edges, which sets the worst-case delay.
        ctrl_nxt.cpu_sync    = {ctrl_r.cpu_sync[0], cpu_stop_n};
        ctrl_nxt.pci_sync    = {ctrl_r.pci_sync[0], pci_stop_n};
        ctrl_nxt.supply_sync = {ctrl_r.supply_sync[0], supply_ok};
        ctrl_nxt.strap_s1    = dual_in;
        ctrl_nxt.strap_s2    = ctrl_r.strap_s1;

        // Power-up runs once: wait for a good supply, capture the straps, hold
        // the dual pins low while the timer runs, then let them toggle. The
        // straps come from the synchronised pin copy, so a level still settling
        // when the supply comes good cannot reach the selection half-resolved.
        // Only a power-on reset leads back to the capture state.
        case (ctrl_r.pwr)
            PWR_WAIT_SUPPLY: begin
                // Pins stay inputs; the pull-up makes an open pin read as one.
                ctrl_nxt.dual.oe  = DUAL_LOW;
                ctrl_nxt.dual.out = DUAL_LOW;
                if (ctrl_r.supply_sync[1]) begin
                    ctrl_nxt.sel       = ctrl_r.strap_s2;
                    ctrl_nxt.sel_valid = 1'b1;
                    ctrl_nxt.timer     = TIMER_RESET;
                    ctrl_nxt.pwr       = PWR_HOLD_LOW;
                end
            end
            PWR_HOLD_LOW: begin
                ctrl_nxt.dual.oe  = {DUAL_PINS{1'b1}};
                ctrl_nxt.dual.out = DUAL_LOW;
                if (ctrl_r.timer == TIMER_LAST) begin
                    ctrl_nxt.pwr = PWR_RUN;
                end else begin
                    ctrl_nxt.timer = ctrl_r.timer + TIMER_W'(1);
                end
            end
            PWR_RUN: begin
                // Selections are frozen here; only a power-on reset captures again.
                ctrl_nxt.dual.oe  = {DUAL_PINS{1'b1}};
                ctrl_nxt.dual.out = {DUAL_PINS{ctrl_nxt.pci_free}};
            end
            default: begin
                ctrl_nxt.pwr = PWR_WAIT_SUPPLY;
            end
        endcase
    end

    assign cpu_wave_nxt = wave_of(ctrl_nxt.div, CPU_DIV_BIT);
    assign pci_wave_nxt = wave_of(ctrl_nxt.div, PCI_DIV_BIT);

    // Reset values are spelled out per field so that each pin-facing register
    // starts at its idle level: the stop synchronisers read running, the strap
    // copies read one as an open pin would, and no dual pin is driven.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r.div         <= DIV_RESET;
            ctrl_r.cpu_sync    <= SYNC_IDLE;
            ctrl_r.pci_sync    <= SYNC_IDLE;
            ctrl_r.supply_sync <= 2'h0;
            ctrl_r.strap_s1    <= STRAP_RESET;
            ctrl_r.strap_s2    <= STRAP_RESET;
            ctrl_r.pwr         <= PWR_WAIT_SUPPLY;
            ctrl_r.timer       <= TIMER_RESET;
            ctrl_r.sel         <= STRAP_RESET;
            ctrl_r.sel_valid   <= 1'b0;
            ctrl_r.dual.out    <= DUAL_LOW;
            ctrl_r.dual.oe     <= DUAL_LOW;
            ctrl_r.pci_free    <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Stop latency, counted in clk edges from the pin change: two edges pass
    // through the synchroniser, and the gate then waits for a point where the
    // next wave level is low before it moves its enable.
    // For the CPU wave (clk/2) that wait is at most one edge, so a halt or a
    // restart lands within four edges, inside two CPU periods.
    // For the PCI wave (clk/4) the wait can reach two edges; since the chipset
    // moves the pin on a free-running PCI rising edge, the change still lands
    // before the following free-running rising edge.
    // A stop pulse shorter than the synchroniser may be missed entirely; the
    // chipset holds its stop level for whole PCI periods, so this costs nothing.
    //
    // Each gate holds its own enable so every output leaves a flip-flop directly.
    // The CPU gates ignore the PCI stop, and the reverse, so one halt never
    // disturbs the other family.
    genvar gi;
    generate
        for (gi = 0; gi < CPU_CLOCKS; gi++) begin : g_cpu
            clk_gate_cell u_gate (
                .clk      (clk),
                .rst      (rst),
                .wave_nxt (cpu_wave_nxt),
                .run      (ctrl_r.cpu_sync[1]),
                .clk_out  (clk_outs.cpu[gi])
            );
        end
        for (gi = 0; gi < PCI_STOP_CLOCKS; gi++) begin : g_pci
            clk_gate_cell u_gate (
                .clk      (clk),
                .rst      (rst),
                .wave_nxt (pci_wave_nxt),
                .run      (ctrl_r.pci_sync[1]),
                .clk_out  (clk_outs.pci[gi])
            );
        end
    endgenerate

    assign clk_outs.pci_free      = ctrl_r.pci_free;
    assign cpu_clocks             = clk_outs.cpu;
    assign stoppable_pci_clocks   = clk_outs.pci;
    assign free_running_pci_clock = clk_outs.pci_free;
    assign dual_out               = ctrl_r.dual.out;
    assign dual_oe                = ctrl_r.dual.oe;
    assign strap_sel              = ctrl_r.sel;
    assign strap_valid            = ctrl_r.sel_valid;

endmodule
`default_nettype wire

// ==== hdl/clk_stop_pkg.sv ====
// Constants and carriers shared by the clock stop and strap capture logic.
// Assumes a single 125 MHz synthesizer clock from which every output clock is divided.
package clk_stop_pkg;

    localparam int unsigned CLK_PERIOD_NS    = 8;
    localparam int unsigned CLK_RATE_KHZ     = 125000;

    // Output clock counts and the divider that makes them.
    localparam int unsigned CPU_CLOCKS       = 4;
    localparam int unsigned PCI_STOP_CLOCKS  = 6;
    localparam int unsigned DUAL_PINS        = 5;
    localparam int unsigned DIV_W            = 2;
    localparam logic [DIV_W-1:0] DIV_RESET   = 2'h0;
    localparam int unsigned CPU_DIV_BIT      = 0;
    localparam int unsigned PCI_DIV_BIT      = 1;

    // Power-up timer; a longest time, so the cycle count rounds down.
    localparam int unsigned POWERUP_TIME_MS  = 3;
    localparam int unsigned POWERUP_CYCLES_DEF = (POWERUP_TIME_MS * CLK_RATE_KHZ);
    localparam int unsigned TIMER_W          = 19;
    localparam logic [TIMER_W-1:0] TIMER_RESET = 19'h00000;

    // Reset values of the pin-facing state.
    localparam logic [DUAL_PINS-1:0] STRAP_RESET = 5'h1F;
    localparam logic [DUAL_PINS-1:0] DUAL_LOW    = 5'h00;
    localparam logic [1:0]           SYNC_IDLE   = 2'h3;

    typedef enum logic [2:0] {
        PWR_WAIT_SUPPLY = 3'b001,
        PWR_HOLD_LOW    = 3'b010,
        PWR_RUN         = 3'b100
    } pwr_state_e;

    // Clock outputs travelling together.
    typedef struct packed {
        logic [CPU_CLOCKS-1:0]      cpu;
        logic [PCI_STOP_CLOCKS-1:0] pci;
        logic                       pci_free;
    } clk_outs_s;

    // Dual-function pins as two signals each.
    typedef struct packed {
        logic [DUAL_PINS-1:0] out;
        logic [DUAL_PINS-1:0] oe;
    } dual_drive_s;

    // State of one glitch-free gate.
    typedef struct packed {
        logic en;
        logic out;
    } gate_s;

endpackage

// ==== hdl/clk_gate_cell.sv ====
// One glitch-free output gate for a divided clock.
// Assumes wave_nxt is the next value of the ungated clock and run is already synchronised.
`timescale 1ns/10ps
`default_nettype none
module clk_gate_cell
    import clk_stop_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic wave_nxt,
    input  wire logic run,
    // Gated clock
    output logic      clk_out
);

    gate_s state_r;
    gate_s state_nxt;

    // The enable may only move while the next output level is low, so a halt
    // always lands in the low state and a restart begins with a whole high phase.
    always_comb begin
        state_nxt = state_r;
        if (!wave_nxt) begin
            state_nxt.en = run;
        end
        state_nxt.out = wave_nxt & state_nxt.en;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign clk_out = state_r.out;

endmodule
`default_nettype wire

// ==== sim/stop_ctrl_model.sv ====
// Chipset power management model that drives the two stop pins.
// Assumes requests come from the bench; pins move only at free PCI clock rises.
`timescale 1ns/10ps
`default_nettype none
module stop_ctrl_model (
    // Clock and reset
    input  wire logic free_running_pci_clock,
    input  wire logic rst,
    // Requests from the bench
    input  wire logic want_cpu,
    input  wire logic want_pci,
    // Stop pins
    output logic      cpu_stop_n,
    output logic      pci_stop_n
);
    always_ff @(posedge free_running_pci_clock or posedge rst) begin
        if (rst) begin
            cpu_stop_n <= 1'b1;
            pci_stop_n <= 1'b1;
        end else begin
            cpu_stop_n <= ~want_cpu;
            pci_stop_n <= ~want_pci;
        end
    end
endmodule
`default_nettype wire

// ==== sim/clk_stop_props.sv ====
// Checker for clock stop gating and strap capture.
// Assumes it is bound onto the top module with the same POWERUP_CYCLES.
`timescale 1ns/10ps
`default_nettype none
module clk_stop_checker
    import clk_stop_pkg::*;
#(
    parameter int unsigned POWERUP_CYCLES = POWERUP_CYCLES_DEF
)(
    // Clock, reset and stop pins
    input wire logic                       clk,
    input wire logic                       rst,
    input wire logic                       cpu_stop_n,
    input wire logic                       pci_stop_n,
    // Watched outputs
    input wire logic [DUAL_PINS-1:0]       dual_out,
    input wire logic [DUAL_PINS-1:0]       dual_oe,
    input wire logic [DUAL_PINS-1:0]       strap_sel,
    input wire logic                       strap_valid,
    input wire logic [CPU_CLOCKS-1:0]      cpu_clocks,
    input wire logic [PCI_STOP_CLOCKS-1:0] stoppable_pci_clocks,
    input wire logic                       free_running_pci_clock
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Counts cycles since capture, saturating, to bound the low hold.
    int unsigned held_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) held_r <= 0;
        else if (strap_valid && held_r < POWERUP_CYCLES) held_r <= held_r + 1;
    end
    cpu_halt_a: assert property (!cpu_stop_n [*5] |-> cpu_clocks == 4'h0)
        else $error("cpu clocks not halted");
    cpu_resume_a: assert property (cpu_stop_n [*6] |-> cpu_clocks != $past(cpu_clocks))
        else $error("cpu clocks not running");
    cpu_pulse_a: assert property (cpu_clocks[0] |=> !cpu_clocks[0])
        else $error("cpu high phase too long");
    pci_halt_a: assert property (!pci_stop_n [*8] |-> stoppable_pci_clocks == 6'h00)
        else $error("pci clocks not halted");
    pci_pulse_a: assert property ($rose(stoppable_pci_clocks[0])
        |=> stoppable_pci_clocks[0] ##1 !stoppable_pci_clocks[0])
        else $error("pci pulse truncated");
    pci_phase_a: assert property (stoppable_pci_clocks[0] |-> free_running_pci_clock)
        else $error("pci gate out of phase");
    free_run_a: assert property ($rose(free_running_pci_clock) |=> free_running_pci_clock
        ##1 !free_running_pci_clock [*2] ##1 free_running_pci_clock)
        else $error("free clock interrupted");
    strap_hold_a: assert property (strap_valid |=> strap_valid && $stable(strap_sel))
        else $error("strap changed after capture");
    dual_input_a: assert property (!strap_valid |-> dual_oe == 5'h00)
        else $error("dual pin driven before capture");
    dual_low_a: assert property ($rose(strap_valid) |=> dual_oe == 5'h1F && dual_out == 5'h00)
        else $error("dual pins not driven low");
    dual_hold_a: assert property (strap_valid && held_r < POWERUP_CYCLES |-> dual_out == 5'h00)
        else $error("dual pins toggle early");
    cov_cpu: cover property (!cpu_stop_n [*5]);
    cov_pci: cover property (!pci_stop_n [*8]);
    cov_strap: cover property ($rose(strap_valid));
endmodule
bind clk_stop_power_control clk_stop_checker #(.POWERUP_CYCLES(POWERUP_CYCLES)) i_clk_stop_checker (
    .clk(clk), .rst(rst), .cpu_stop_n(cpu_stop_n), .pci_stop_n(pci_stop_n),
    .dual_out(dual_out), .dual_oe(dual_oe), .strap_sel(strap_sel), .strap_valid(strap_valid),
    .cpu_clocks(cpu_clocks), .stoppable_pci_clocks(stoppable_pci_clocks),
    .free_running_pci_clock(free_running_pci_clock));
`default_nettype wire

// ==== sim/clock_stop_power_control_bench.sv ====
// Self-checking bench for clock stop gating and strap capture.
// Assumes the chipset model drives the stop pins; straps resolve with pull-ups.
`timescale 1ns/10ps
`default_nettype none
module clock_stop_power_control_bench
    import clk_stop_pkg::*;
;
    logic        clk, rst, supply_ok, want_cpu, want_pci, arm, probe, sv_d;
    logic        cpu_stop_n, pci_stop_n, strap_valid, free_running_pci_clock;
    logic [4:0]  drv_en, drv_val, dual_in, dual_out, dual_oe, strap_sel;
    logic [3:0]  cpu_clocks;
    logic [5:0]  stoppable_pci_clocks;
    logic [15:0] acc, r;
    logic [15:0] exp_q[$];
    int          fails, samples_checked, seed;
    // Undriven strap pins read high through the pull-up.
    assign dual_in = (dual_oe & dual_out) | (~dual_oe & ((drv_en & drv_val) | ~drv_en));
    clk_stop_power_control #(.POWERUP_CYCLES(20)) i_clk_stop_power_control (
        .clk                    (clk),
        .rst                    (rst),
        .cpu_stop_n             (cpu_stop_n),
        .pci_stop_n             (pci_stop_n),
        .supply_ok              (supply_ok),
        .dual_in                (dual_in),
        .dual_out               (dual_out),
        .dual_oe                (dual_oe),
        .strap_sel              (strap_sel),
        .strap_valid            (strap_valid),
        .cpu_clocks             (cpu_clocks),
        .stoppable_pci_clocks   (stoppable_pci_clocks),
        .free_running_pci_clock (free_running_pci_clock)
    );
    stop_ctrl_model i_stop_ctrl_model (
        .free_running_pci_clock (free_running_pci_clock),
        .rst                    (rst),
        .want_cpu               (want_cpu),
        .want_pci               (want_pci),
        .cpu_stop_n             (cpu_stop_n),
        .pci_stop_n             (pci_stop_n)
    );
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic check(input logic [15:0] got);
        logic [15:0] e;
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX;
        samples_checked++;
        if (got !== e) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask
    always @(posedge clk) begin
        acc <= arm ? 16'h0000 : acc | {dual_out, cpu_clocks, stoppable_pci_clocks,
            free_running_pci_clock};
        if (strap_valid && !sv_d) check({strap_sel, 11'h000});
        if (probe) check(acc);
        sv_d <= strap_valid;
    end
    task automatic window(input logic wc, input logic wp, input logic [4:0] d, input int n);
        want_cpu = wc;
        want_pci = wp;
        repeat (n) @(negedge clk);
        arm = 1'b1;
        @(negedge clk);
        arm = 1'b0;
        exp_q.push_back({d, wc ? 4'h0 : 4'hF, wp ? 6'h00 : 6'h3F, 1'b1});
        repeat (8) @(negedge clk);
        probe = 1'b1;
        @(negedge clk);
        probe = 1'b0;
    endtask
    task automatic complete_run;
        fails += exp_q.size();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #100000;
        fails++;
        complete_run();
    end
    initial begin
        seed = 32'h43570716;
        {rst, supply_ok, want_cpu, want_pci, arm, probe, sv_d} = 7'h40;
        {drv_en, drv_val, acc, fails, samples_checked} = '0;
        for (int p = 0; p < 2; p++) begin
            @(negedge clk);
            {rst, supply_ok, want_cpu, want_pci} = 4'h8;
            drv_en = 5'($random(seed));
            drv_val = 5'($random(seed));
            exp_q.push_back({(drv_en & drv_val) | ~drv_en, 11'h000});
            repeat (8) @(negedge clk);
            rst = 1'b0;
            repeat (3) @(negedge clk);
            supply_ok = 1'b1;
            for (int i = 0; i < 20 && strap_valid !== 1'b1; i++) @(negedge clk);
            drv_val = ~drv_val;
            supply_ok = 1'b0;
            window(1'b0, 1'b0, 5'h00, 1);
            supply_ok = 1'b1;
            for (int k = 0; k < 12; k++) begin
                r = (k < 4) ? 16'(k) : 16'($random(seed));
                window(r[0], r[1], 5'h1F, 12);
            end
        end
        complete_run();
    end
endmodule
`default_nettype wire
